// ### verilog/arpw_writer.sv
// Receive packet writer: link quadlets into request and response buffers
module arpw_writer (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_rx_valid,
  input wire arpw_pkg::arpw_rx_t i_rx,
  output logic o_rx_ready,
  input wire logic i_ack_valid,
  input wire logic i_ack_data_error,
  input wire logic [4:0] i_ack_code,
  input wire logic i_bus_reset,
  input wire logic [7:0] i_topology_generation,
  input wire logic [2:0] i_seconds_count,
  input wire logic [12:0] i_cycle_number,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output arpw_pkg::arpw_mem_t o_mem,
  output logic o_bus_reset_interrupt,
  output logic o_request_packet_interrupt,
  output logic o_response_packet_interrupt,
  output logic o_request_buffer_done_interrupt,
  output logic o_response_buffer_done_interrupt
);
  import arpw_pkg::*;

  typedef enum {
    S_IDLE, S_HOLD, S_Q0, S_Q1, S_BODY, S_DROP, S_ACK, S_TRAIL,
    S_PH_HDR, S_PH_Q, S_PH_INV, S_MK_HDR, S_MK_GEN, S_MK_TRL
  } arpw_state_t;

  arpw_state_t state_reg;
  arpw_state_t state_next;
  logic [31:0] q0_reg;
  logic [31:0] q1_reg;
  logic last_reg;
  logic ctx_reg;
  logic [15:0] off_reg;
  logic [15:0] ts_reg;
  logic [7:0] gen_reg;
  logic [4:0] ev_reg;
  logic [7:0] ctrl_reg;
  logic [1:0][15:0] cc_reg;
  logic [1:0][15:0] res_reg;
  logic [1:0][15:0] wptr_reg;
  logic [1:0] full_reg;
  logic mark_pend_reg;
  arpw_retry_t retry_reg;
  logic rst_rise;
  logic rx_fire;
  logic mark_go;
  logic wr_req;
  logic wr_en;
  logic [31:0] wr_data;
  logic commit;
  logic backout;
  logic start_pkt;
  logic [17:0] need;
  logic [15:0] res_after;
  logic over;
  logic hold_ctx;
  logic phy_seen;
  logic [15:0] phy_hdr;
  logic [31:0] trailer;

  arpw_sync u_bus_reset_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async(i_bus_reset),
    .o_rise(rst_rise)
  );

  assign rx_fire = i_rx_valid & o_rx_ready;
  assign hold_ctx = arpw_tc_ctx(q0_reg[TC_LSB+:4]);
  assign phy_seen = i_rx.last & i_rx.crc_fail;
  assign need = {2'b00, off_reg + 16'h0001} << 2;
  assign res_after = res_reg[ctx_reg] - need[15:0];
  assign over = need > {2'b00, res_reg[ctx_reg]};
  // Marker only while request context runs and has room
  assign mark_go = mark_pend_reg & ctrl_reg[CTL_RQ_ACT]
                   & ~full_reg[CTX_RQ];
  assign phy_hdr = 16'(TC_PHY) << TC_LSB;
  assign trailer = {cc_reg[ctx_reg][15:5], ev_reg, ts_reg};
  assign wr_en = wr_req & ~over;

  always_comb begin
    state_next = state_reg;
    o_rx_ready = 1'b0;
    wr_req = 1'b0;
    wr_data = q0_reg;
    commit = 1'b0;
    backout = 1'b0;
    start_pkt = 1'b0;
    case (state_reg)
      S_IDLE: begin
        o_rx_ready = ~mark_go;
        if (mark_go) begin
          state_next = S_MK_HDR;
        end else if (i_rx_valid && i_rx.first && !i_rx.last) begin
          start_pkt = 1'b1;
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        o_rx_ready = ~full_reg[hold_ctx];
        if (i_rx_valid && !full_reg[hold_ctx]) begin
          if (phy_seen) begin
            if (ctrl_reg[CTL_PHY_EN] && ctrl_reg[CTL_RQ_ACT]) begin
              state_next = S_PH_HDR;
            end else begin
              state_next = S_IDLE;
            end
          end else if (!arpw_tc_defined(q0_reg[TC_LSB+:4]) || i_rx.crc_fail
                       || !ctrl_reg[CTL_RQ_ACT + 32'(hold_ctx)]) begin
            state_next = i_rx.last ? S_IDLE : S_DROP;
          end else begin
            state_next = S_Q0;
          end
        end
      end
      S_Q0: begin
        wr_req = 1'b1;
        state_next = S_Q1;
      end
      S_Q1: begin
        wr_req = 1'b1;
        wr_data = q1_reg;
        state_next = last_reg ? S_ACK : S_BODY;
      end
      S_BODY: begin
        o_rx_ready = 1'b1;
        wr_data = i_rx.data;
        if (i_rx_valid) begin
          wr_req = 1'b1;
          if (i_rx.last) begin
            state_next = S_ACK;
          end
        end
      end
      S_DROP: begin
        o_rx_ready = 1'b1;
        if (i_rx_valid && i_rx.last) begin
          state_next = S_IDLE;
        end
      end
      S_ACK: begin
        if (i_ack_valid) begin
          backout = i_ack_data_error;
          state_next = i_ack_data_error ? S_IDLE : S_TRAIL;
        end
      end
      S_TRAIL, S_MK_TRL: begin
        wr_req = 1'b1;
        wr_data = trailer;
        commit = ~over;
        state_next = S_IDLE;
      end
      S_PH_HDR, S_MK_HDR: begin
        wr_req = 1'b1;
        wr_data = {16'h0000, phy_hdr};
        state_next = (state_reg == S_PH_HDR) ? S_PH_Q : S_MK_GEN;
      end
      S_PH_Q: begin
        wr_req = 1'b1;
        state_next = S_PH_INV;
      end
      S_PH_INV: begin
        wr_req = 1'b1;
        wr_data = q1_reg;
        state_next = S_TRAIL;
      end
      S_MK_GEN: begin
        wr_req = 1'b1;
        wr_data = 32'(gen_reg) << GEN_LSB;
        state_next = S_MK_TRL;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    if (wr_req && over) begin
      backout = 1'b1;
      state_next = (state_reg == S_BODY && !i_rx.last) ? S_DROP : S_IDLE;
    end
    if (rst_rise && state_reg != S_IDLE && state_reg != S_MK_HDR
        && state_reg != S_MK_GEN && state_reg != S_MK_TRL) begin
      backout = 1'b1;
      commit = 1'b0;
      state_next = S_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Packet capture and per-packet offset
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q0_reg <= 32'h0000_0000;
      q1_reg <= 32'h0000_0000;
      last_reg <= 1'b0;
      ctx_reg <= CTX_RQ;
      off_reg <= 16'h0000;
      ts_reg <= 16'h0000;
      gen_reg <= 8'h00;
      ev_reg <= EVT_NO_STATUS;
      retry_reg <= RETRY_1;
    end else begin
      if (start_pkt) begin
        q0_reg <= i_rx.data;
        ts_reg <= {i_seconds_count, i_cycle_number};
      end
      if (state_reg == S_IDLE && mark_go) begin
        ctx_reg <= CTX_RQ;
        gen_reg <= i_topology_generation;
        ts_reg <= {i_seconds_count, i_cycle_number};
        ev_reg <= EVT_BUS_RESET;
      end
      if (state_reg == S_HOLD && rx_fire) begin
        q1_reg <= i_rx.data;
        last_reg <= i_rx.last;
        ctx_reg <= phy_seen ? CTX_RQ : hold_ctx;
        ev_reg <= EVT_NO_STATUS;
        retry_reg <= arpw_retry(q0_reg[RT_LSB+:2]);
      end
      if (state_reg == S_ACK && i_ack_valid) begin
        ev_reg <= i_ack_code;
      end
      if (state_reg == S_IDLE || backout) begin
        off_reg <= 16'h0000;
      end else if (wr_en) begin
        off_reg <= off_reg + 16'h0001;
      end
    end
  end

  // Buffer write port
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mem <= '0;
    end else begin
      o_mem.valid <= wr_en;
      o_mem.ctx <= ctx_reg;
      o_mem.addr <= wptr_reg[ctx_reg] + off_reg;
      o_mem.data <= wr_data;
    end
  end

  // Marker request survives until written, or until the request context is found inactive in idle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mark_pend_reg <= 1'b0;
    end else if (rst_rise) begin
      mark_pend_reg <= 1'b1;
    end else if (state_reg == S_MK_TRL && commit) begin
      mark_pend_reg <= 1'b0;
    end else if (state_reg == S_IDLE && !ctrl_reg[CTL_RQ_ACT]) begin
      mark_pend_reg <= 1'b0;
    end
  end

  // Buffer residue, write pointer and full flag
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      res_reg <= {RES_RESET, RES_RESET};
      wptr_reg <= '0;
      full_reg <= 2'b00;
    end else begin
      if (commit) begin
        res_reg[ctx_reg] <= res_after;
        wptr_reg[ctx_reg] <= wptr_reg[ctx_reg] + off_reg + 16'h0001;
      end
      if (i_reg_wr && (i_reg_addr == REG_RES_RQ
                       || i_reg_addr == REG_RES_RS)) begin
        res_reg[i_reg_addr == REG_RES_RS] <= i_reg_wdata[15:0];
        wptr_reg[i_reg_addr == REG_RES_RS] <= 16'h0000;
        full_reg[i_reg_addr == REG_RES_RS] <= 1'b0;
      end
      if (commit && res_after < MIN_FREE_BYTES) begin
        full_reg[ctx_reg] <= 1'b1;
      end
    end
  end

  // Event pulses
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_bus_reset_interrupt <= 1'b0;
      o_request_packet_interrupt <= 1'b0;
      o_response_packet_interrupt <= 1'b0;
      o_request_buffer_done_interrupt <= 1'b0;
      o_response_buffer_done_interrupt <= 1'b0;
    end else begin
      o_bus_reset_interrupt <= rst_rise;
      o_request_packet_interrupt <= commit & (ctx_reg == CTX_RQ);
      o_response_packet_interrupt <= commit & (ctx_reg == CTX_RS);
      o_request_buffer_done_interrupt <= commit & (ctx_reg == CTX_RQ)
        & (res_after < MIN_FREE_BYTES)
        & (ctrl_reg[CTL_RQ_INT+:2] == INT_BUF_DONE);
      o_response_buffer_done_interrupt <= commit & (ctx_reg == CTX_RS)
        & (res_after < MIN_FREE_BYTES)
        & (ctrl_reg[CTL_RQ_INT+2+:2] == INT_BUF_DONE);
    end
  end

  // Control registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_reg <= CTRL_RESET;
      cc_reg <= '0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == REG_CTRL) begin
        ctrl_reg <= i_reg_wdata[7:0];
      end
      if (i_reg_addr == REG_CC_RQ) begin
        cc_reg[CTX_RQ] <= i_reg_wdata[15:0];
      end
      if (i_reg_addr == REG_CC_RS) begin
        cc_reg[CTX_RS] <= i_reg_wdata[15:0];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_CTRL: o_reg_rdata <= {24'h000000, ctrl_reg};
        REG_CC_RQ: o_reg_rdata <= {16'h0000, cc_reg[CTX_RQ]};
        REG_CC_RS: o_reg_rdata <= {16'h0000, cc_reg[CTX_RS]};
        REG_RES_RQ: o_reg_rdata <= {16'h0000, res_reg[CTX_RQ]};
        REG_RES_RS: o_reg_rdata <= {16'h0000, res_reg[CTX_RS]};
        REG_STATUS: begin
          o_reg_rdata <= {27'h0000000, retry_reg, mark_pend_reg, full_reg};
        end
        default: o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence mark_walk_s;
    state_reg == S_MK_HDR ##1 state_reg == S_MK_GEN
      ##1 (state_reg == S_MK_TRL && commit);
  endsequence

  sequence phy_walk_s;
    state_reg == S_PH_HDR ##1 state_reg == S_PH_Q
      ##1 (state_reg == S_PH_INV && !rst_rise);
  endsequence

  bus_rst_irq_a: assert property (
    rst_rise |=> o_bus_reset_interrupt)
    else $error("bus reset interrupt late");

  mark_tcode_a: assert property (
    state_reg == S_MK_HDR && wr_en |=> o_mem.data[TC_LSB+:4] == TC_PHY)
    else $error("marker code wrong");

  mark_event_a: assert property (
    mark_walk_s |=> o_mem.valid && o_mem.data[EV_LSB+:5] == EVT_BUS_RESET)
    else $error("marker event wrong");

  mark_irq_a: assert property (
    mark_walk_s |=> o_request_packet_interrupt && !o_mem.ctx)
    else $error("marker not signalled");

  data_err_keep_a: assert property (
    state_reg == S_ACK && i_ack_valid && i_ack_data_error && !i_reg_wr
      |=> $stable(res_reg) ##1 !o_request_packet_interrupt
          && !o_response_packet_interrupt)
    else $error("errored packet committed");

  phy_gate_a: assert property (
    state_reg == S_HOLD && rx_fire && phy_seen && !ctrl_reg[CTL_PHY_EN]
      |=> state_reg == S_IDLE)
    else $error("phy packet taken while off");

  phy_copy_a: assert property (
    phy_walk_s |=> o_mem.data == $past(q1_reg, 1) ##1 state_reg == S_IDLE)
    else $error("phy copy quadlet lost");

  undef_drop_a: assert property (
    state_reg == S_HOLD && rx_fire && !phy_seen
      && !arpw_tc_defined(q0_reg[TC_LSB+:4])
      |=> (state_reg == S_DROP || state_reg == S_IDLE) ##1 !o_mem.valid)
    else $error("undefined code stored");

  trail_last_a: assert property (
    state_reg == S_TRAIL && commit |=> state_reg == S_IDLE
      && o_mem.valid && o_mem.data[15:0] == ts_reg)
    else $error("trailer not last");
endmodule

// ### verilog/arpw_pkg.sv
// Constants, carriers and decoders for the receive packet writer
// Notes on behaviour
// - Data-error packet backed out, residual untouched
// - Reset before ack may back packet out
// - Bus reset queues marker into active request buffer
// - Marker header transaction code is hex E
// - Marker holds generation sampled at creation
// - Marker reserved and undefined bits: any value
// - Marker event field is 5'h09
// - Back-to-back resets need only one marker
// - Marker held pending until input room frees
// - Marker deferred until request buffer has space
// - Bus reset interrupt raised immediately on detection
// - Stored marker raises request packet interrupt
// - PHY packets stored only when enable set
// - PHY packet keeps its inverted-copy quadlet
// - Two-quadlet CRC failures handled as PHY packets
// - Per-packet and buffer-done interrupts per context
// - Undefined transaction codes dropped
// - Reserved header bits stored unaltered
// - First payload byte in top byte lane
// - Trailer: transfer status plus sampled time tag
// - Block header fourth quadlet length and lock code
// - Retry code decodes to retry1, X, A, B
// - Header, then payload, then trailer written
package arpw_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CC_RQ = 8'h04;
  localparam logic [7:0] REG_CC_RS = 8'h08;
  localparam logic [7:0] REG_RES_RQ = 8'h0c;
  localparam logic [7:0] REG_RES_RS = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTL_PHY_EN = 0;
  localparam int CTL_RQ_ACT = 1;
  localparam int CTL_RQ_INT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int TC_LSB = 4;
  localparam int RT_LSB = 8;
  localparam int GEN_LSB = 16;
  localparam int EV_LSB = 16;
  localparam logic [3:0] TC_PHY = 4'he;
  localparam logic [4:0] EVT_BUS_RESET = 5'h09;
  localparam logic [4:0] EVT_NO_STATUS = 5'h00;
  localparam logic [1:0] INT_BUF_DONE = 2'b11;
  localparam logic [15:0] MIN_FREE_BYTES = 16'h0014;
  localparam logic [15:0] RES_RESET = 16'h0000;
  localparam logic CTX_RQ = 1'b0;
  localparam logic CTX_RS = 1'b1;

  typedef struct packed {
    logic [31:0] data;
    logic first;
    logic last;
    logic crc_fail;
  } arpw_rx_t;

  typedef struct packed {
    logic valid;
    logic ctx;
    logic [15:0] addr;
    logic [31:0] data;
  } arpw_mem_t;

  typedef enum logic [1:0] {RETRY_1, RETRY_X, RETRY_A, RETRY_B} arpw_retry_t;

  function automatic logic arpw_tc_defined(input logic [3:0] tc);
    case (tc)
      4'h3, 4'h8, 4'hc, 4'hd, 4'hf: arpw_tc_defined = 1'b0;
      default: arpw_tc_defined = 1'b1;
    endcase
  endfunction

  function automatic logic arpw_tc_ctx(input logic [3:0] tc);
    case (tc)
      4'h2, 4'h6, 4'h7, 4'hb: arpw_tc_ctx = CTX_RS;
      default: arpw_tc_ctx = CTX_RQ;
    endcase
  endfunction

  function automatic arpw_retry_t arpw_retry(input logic [1:0] rt);
    case (rt)
      2'b00: arpw_retry = RETRY_1;
      2'b01: arpw_retry = RETRY_X;
      2'b10: arpw_retry = RETRY_A;
      default: arpw_retry = RETRY_B;
    endcase
  endfunction
endpackage

// ### verilog/arpw_sync.sv
// Two-stage synchroniser with a rising-edge pulse
module arpw_sync (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_rise
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign o_rise = sync_reg & ~prev_reg;
endmodule

// ### bench/arpw_link_model.sv
// Link-side receive FIFO model that offers packets one quadlet at a time
module arpw_link_model (
  input wire logic i_clk_sys,
  input wire logic i_rx_ready,
  output logic o_rx_valid,
  output arpw_pkg::arpw_rx_t o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import arpw_pkg::*;
  int n_stall = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx = '0;
  end
  // Quadlet held until taken; when a gap follows it or it is the last quadlet, released data shows its inverse
  task automatic send(input logic [31:0] q[$], input logic bad,
                      input int gap);
    int w;
    for (int i = 0; i < q.size(); i++) begin
      o_rx_valid <= 1'b1;
      o_rx.data <= q[i];
      o_rx.first <= (i == 0);
      o_rx.last <= (i == q.size() - 1);
      o_rx.crc_fail <= bad && (i == q.size() - 1);
      w = 0;
      do begin
        @(posedge i_clk_sys);
        w++;
      end while (i_rx_ready !== 1'b1 && w < 200);
      if (w >= 200) n_stall++;
      if (gap > 0 || i == q.size() - 1) begin
        o_rx_valid <= 1'b0;
        o_rx.data <= ~q[i];
        repeat (gap) @(posedge i_clk_sys);
      end
    end
  endtask
endmodule

// ### bench/arpw_writer_tb.sv
// Self-checking bench for the receive packet writer
module arpw_writer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import arpw_pkg::*;
  localparam logic [15:0] CC = 16'h8400;
  localparam logic [15:0] TS = {3'h5, 13'h0123};
  logic i_clk_sys, i_reset, i_rx_valid, o_rx_ready, i_bus_reset;
  logic i_ack_valid, i_ack_data_error, i_reg_wr, i_reg_rd;
  logic o_bri, o_rqi, o_rsi, o_rqdi, o_rsdi;
  logic [4:0] i_ack_code;
  logic [7:0] i_topology_generation, i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [15:0] ts;
  arpw_rx_t i_rx;
  arpw_mem_t o_mem;
  arpw_mem_t mq[$];
  int n_mismatch = 0, n_checks = 0, n_br = 0, n_rq = 0, n_rs = 0;
  int n_rqd = 0, n_rsd = 0;

  arpw_writer dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_rx_valid(i_rx_valid), .i_rx(i_rx), .o_rx_ready(o_rx_ready),
    .i_ack_valid(i_ack_valid), .i_ack_data_error(i_ack_data_error),
    .i_ack_code(i_ack_code), .i_bus_reset(i_bus_reset),
    .i_topology_generation(i_topology_generation),
    .i_seconds_count(ts[15:13]), .i_cycle_number(ts[12:0]),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_mem(o_mem), .o_bus_reset_interrupt(o_bri),
    .o_request_packet_interrupt(o_rqi), .o_response_packet_interrupt(o_rsi),
    .o_request_buffer_done_interrupt(o_rqdi),
    .o_response_buffer_done_interrupt(o_rsdi));
  arpw_link_model link_u (.i_clk_sys(i_clk_sys), .i_rx_ready(o_rx_ready),
    .o_rx_valid(i_rx_valid), .o_rx(i_rx));

  always @(posedge i_clk_sys) begin
    if (o_mem.valid === 1'b1) mq.push_back(o_mem);
    n_br += (o_bri === 1'b1);
    n_rq += (o_rqi === 1'b1);
    n_rs += (o_rsi === 1'b1);
    n_rqd += (o_rqdi === 1'b1);
    n_rsd += (o_rsdi === 1'b1);
  end

  task automatic chk(input logic [49:0] g, input logic [49:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cm(input int i, input logic c, input logic [15:0] a,
                    input logic [31:0] d);
    chk(mq[i], {1'b1, c, a, d});
  endtask
  function automatic logic [31:0] trl(input logic [4:0] code);
    return {CC[15:5], code, ts};
  endfunction
  function automatic logic [31:0] hdr(input logic [3:0] tc,
                                      input logic [1:0] rt);
    return {16'hffc0, 6'h05, rt, tc, 4'h0};
  endfunction
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, e);
  endtask
  task automatic pkt(input logic [31:0] q[$], input logic bad, input int gap,
                     input logic doack, input logic err, input logic [4:0] c);
    @(posedge i_clk_sys);
    link_u.send(q, bad, gap);
    if (doack) begin
      repeat (3) @(posedge i_clk_sys);
      i_ack_valid <= 1'b1;
      i_ack_data_error <= err;
      i_ack_code <= c;
      @(posedge i_clk_sys);
      i_ack_valid <= 1'b0;
      i_ack_data_error <= 1'b0;
    end
  endtask
  task automatic wait_mem(input int n);
    int w = 0;
    while (mq.size() < n && w < 100) begin
      @(posedge i_clk_sys);
      w++;
    end
    repeat (2) @(posedge i_clk_sys);
    chk(mq.size(), n);
  endtask
  task automatic brst(input logic [7:0] g);
    int k;
    @(posedge i_clk_sys);
    k = n_br;
    i_topology_generation <= g;
    i_bus_reset <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_bus_reset <= 1'b0;
    #1;
    chk(n_br, k + 1);
    repeat (4) @(posedge i_clk_sys);
  endtask

  task automatic t_regs();
    rchk(REG_CTRL, {24'h0, CTRL_RESET});
    rchk(REG_RES_RQ, {16'h0, RES_RESET});
    rchk(REG_STATUS, 32'h0);
    reg_wr(8'hfc, 32'hffffffff);
    rchk(8'hfc, 32'h0);
    reg_wr(REG_CC_RQ, {16'h0, CC});
    reg_wr(REG_CC_RS, {16'h0, CC});
    rchk(REG_CC_RQ, {16'h0, CC});
    $display("t_regs done");
  endtask
  task automatic t_norm();
    logic [31:0] q[$];
    int k;
    reg_wr(REG_CTRL, 32'h02);
    reg_wr(REG_RES_RQ, 32'h100);
    for (int r = 0; r < 4; r++) begin
      q = '{hdr(4'h4, 2'(r)), 32'hffc1ffff, 32'hf0000a5c};
      mq.delete();
      k = n_rq;
      pkt(q, 1'b0, 0, 1'b1, 1'b0, 5'h11);
      wait_mem(4);
      for (int j = 0; j < 3; j++) cm(j, CTX_RQ, 16'(r * 4 + j), q[j]);
      cm(3, CTX_RQ, 16'(r * 4 + 3), trl(5'h11));
      chk(n_rq, k + 1);
      rchk(REG_STATUS, {27'h0, 2'(r), 3'h0});
    end
    rchk(REG_RES_RQ, 32'hc0);
    $display("t_norm done");
  endtask
  task automatic t_err();
    logic [31:0] q[$];
    logic [3:0] tcs[5] = '{4'h3, 4'h8, 4'hc, 4'hd, 4'hf};
    int k;
    q = '{hdr(4'h4, 2'b00), 32'hffc1ffff, 32'hf0000a5c};
    reg_wr(REG_RES_RQ, 32'h100);
    k = n_rq;
    pkt(q, 1'b0, 0, 1'b1, 1'b1, 5'h1d);
    repeat (10) @(posedge i_clk_sys);
    chk(n_rq, k);
    rchk(REG_RES_RQ, 32'h100);
    mq.delete();
    pkt(q, 1'b0, 0, 1'b1, 1'b0, 5'h11);
    wait_mem(4);
    cm(0, CTX_RQ, 16'h0, q[0]);
    mq.delete();
    k = n_rq + n_rs;
    for (int i = 0; i < 5; i++) begin
      q[0] = hdr(tcs[i], 2'b00);
      pkt(q, 1'b0, 0, 1'b1, 1'b0, 5'h11);
    end
    repeat (10) @(posedge i_clk_sys);
    chk(mq.size(), 0);
    chk(n_rq + n_rs, k);
    $display("t_err done");
  endtask
  task automatic t_phy();
    logic [31:0] q[$];
    int k;
    q = '{32'h00ff1234, ~32'h00ff1234};
    reg_wr(REG_RES_RQ, 32'h100);
    mq.delete();
    pkt(q, 1'b1, 0, 1'b0, 1'b0, 5'h0);
    repeat (10) @(posedge i_clk_sys);
    chk(mq.size(), 0);
    reg_wr(REG_CTRL, 32'h03);
    k = n_rq;
    pkt(q, 1'b1, 0, 1'b0, 1'b0, 5'h0);
    wait_mem(4);
    chk({mq[0].addr, mq[0].data[7:4]}, {16'h0, TC_PHY});
    cm(1, CTX_RQ, 16'h1, q[0]);
    cm(2, CTX_RQ, 16'h2, q[1]);
    cm(3, CTX_RQ, 16'h3, trl(EVT_NO_STATUS));
    chk(n_rq, k + 1);
    $display("t_phy done");
  endtask
  task automatic t_blk();
    logic [31:0] q[$];
    int k;
    int j;
    q = '{hdr(4'h7, 2'b01), 32'hffc10000, 32'h0, 32'h00050000,
          32'h11223344, 32'h55000000};
    reg_wr(REG_CTRL, 32'hc6);
    reg_wr(REG_RES_RS, 32'd44);
    mq.delete();
    k = n_rs;
    j = n_rsd;
    pkt(q, 1'b0, 2, 1'b1, 1'b0, 5'h11);
    wait_mem(7);
    for (int i = 0; i < 6; i++) cm(i, CTX_RS, 16'(i), q[i]);
    cm(6, CTX_RS, 16'h6, trl(5'h11));
    chk(n_rs, k + 1);
    chk(n_rsd, j + 1);
    rchk(REG_STATUS, 32'h0a);
    rchk(REG_RES_RS, 32'd16);
    reg_wr(REG_RES_RS, 32'h100);
    $display("t_blk done");
  endtask
  task automatic t_brst();
    logic [31:0] q[$];
    int k;
    q = '{hdr(4'h4, 2'b00), 32'hffc1ffff, 32'hf0000a5c};
    reg_wr(REG_CTRL, 32'h32);
    reg_wr(REG_RES_RQ, 32'd20);
    mq.delete();
    k = n_rqd;
    pkt(q, 1'b0, 0, 1'b1, 1'b0, 5'h11);
    wait_mem(4);
    chk(n_rqd, k + 1);
    mq.delete();
    k = n_rq;
    brst(8'h20);
    brst(8'h21);
    chk(mq.size(), 0);
    rchk(REG_STATUS, 32'h05);
    @(posedge i_clk_sys);
    ts <= 16'h4abc;
    reg_wr(REG_RES_RQ, 32'h100);
    wait_mem(3);
    chk({mq[0].addr, mq[0].data[7:4]}, {16'h0, TC_PHY});
    chk({mq[1].addr, mq[1].data[23:16]}, {16'h1, 8'h21});
    cm(2, CTX_RQ, 16'h2, trl(EVT_BUS_RESET));
    chk(n_rq, k + 1);
    repeat (10) @(posedge i_clk_sys);
    chk(mq.size(), 3);
    $display("t_brst done");
  endtask

  task automatic complete_run();
    chk(link_u.n_stall, 0);
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_reset = 1'b1;
    i_bus_reset = 1'b0;
    i_ack_valid = 1'b0;
    i_ack_data_error = 1'b0;
    i_ack_code = 5'h0;
    i_topology_generation = 8'h0;
    ts = TS;
    i_reg_addr = 8'h0;
    i_reg_wdata = 32'h0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_regs();
    t_norm();
    t_err();
    t_phy();
    t_blk();
    t_brst();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    complete_run();
  end
endmodule
